// *** design/cscp_charger_pins.sv ***
// cscp_charger_pins: pin control and status logic of a single-cell charger
// assumes analog comparator flags arrive synchronous to clock; open-drain pins resolved outside
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module cscp_charger_pins
    import cscp_pkg::*;
(
    input  wire logic        clock,           // 25 MHz system clock
    input  wire logic        rst_b,           // async reset, active low
    // AHB-Lite slave
    input  wire logic        hsel,            // slave select
    input  wire logic [31:0] haddr,           // byte address
    input  wire logic [1:0]  htrans,          // transfer type
    input  wire logic        hwrite,          // write when high
    input  wire logic [2:0]  hsize,           // transfer size
    input  wire logic [31:0] hwdata,          // write data
    input  wire logic        hready,          // bus ready in
    output logic [31:0]      hrdata,          // read data
    output logic             hreadyout,       // slave ready
    output logic             hresp,           // always OKAY
    // pins and analog flags
    input  wire logic        sourceSelect,    // high selects USB default limit
    input  wire logic        charge_enable_pin_n, // charge enable pin, active low
    input  wire logic        aboveUvlo,       // input above undervoltage lockout
    input  wire logic        belowOvp,        // input below overvoltage threshold
    input  wire logic        aboveSleep,      // input above sleep threshold
    input  wire logic        chargeActive,    // charge cycle in progress
    input  wire logic        chargeDone,      // charge completed
    input  wire logic        faultSuspend,    // charge suspended by fault
    input  wire logic        statusEvent,     // one-cycle new status update
    output logic [11:0]      inputLimitMa,    // effective input current limit, mA
    output logic [1:0]       dplusVoltageSet, // D+ driver voltage select
    output logic [1:0]       dminusVoltageSet,// D- driver voltage select
    output logic             chargeEnable,    // battery charging enabled
    output logic             power_good_out_n_oe,    // pull power-good pin low
    output logic             power_good_out_n_o,     // power-good pin drive level
    output logic             statusPin_oe,           // pull status pin low
    output logic             statusPin_o,            // status pin drive level
    output logic             interrupt_pulse_out_n_oe, // pull interrupt pin low
    output logic             interrupt_pulse_out_n_o   // interrupt pin drive level
);

    // register file state
    logic        chargeConfig;        // charge_config_bit
    logic [1:0]  statusFunc;          // status_pin_function_select
    logic [4:0]  limitCode;           // input_current_limit_field
    logic        limitOverride;       // host has written a limit
    logic [1:0]  dplusSet;            // dplus_voltage_set
    logic [1:0]  dminusSet;           // dminus_voltage_set
    logic        next_chargeConfig;
    logic [1:0]  next_statusFunc;
    logic [4:0]  next_limitCode;
    logic        next_limitOverride;
    logic [1:0]  next_dplusSet;
    logic [1:0]  next_dminusSet;


    // the bus side is a plain zero-wait slave: an address phase is
    // latched on its accepting edge, and a write lands one edge later
    // while hwdata stands; reads are prepared from the address phase,
    // so the data phase never needs a wait state
    // hsize is not decoded: only whole-word accesses are expected,
    // a narrower write would still update the whole field
    // bus data-phase capture
    logic        wrPend;              // write data phase pending
    logic [7:0]  wrAddr;              // captured write offset
    logic        next_wrPend;
    logic [7:0]  next_wrAddr;
    logic [31:0] next_hrdata;


    // interrupt width fits 13 bits, blink half period fits 24 bits;
    // both counters run off the single system clock, no divider chain,
    // trading a few flops for a simpler timing picture
    // pin timers
    logic [12:0] intCount;            // interrupt pulse cycles left
    logic [12:0] next_intCount;
    logic [23:0] blinkCount;          // blink half-period counter
    logic [23:0] next_blinkCount;
    logic        blinkPhase;          // low half when 1
    logic        next_blinkPhase;
    logic        faultPrev;           // fault edge detect
    logic        next_faultPrev;
    logic [11:0] next_inputLimitMa;


    // counter reload values, cut to the counter widths on purpose
    localparam logic [12:0] INT_LOAD   = 13'(INT_PULSE_CYC);
    localparam logic [23:0] BLINK_LAST = 24'(BLINK_HALF_CYC - 1);

    wire addrPhase = hsel & hready & htrans[1];  // NONSEQ or SEQ accepted


    // no access is ever refused: unmapped writes are dropped and
    // unmapped reads return zero, so an error response is never needed
    // zero-wait slave; only OKAY responses
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // bus decode and register writes
    always_comb begin
        next_wrPend        = addrPhase & hwrite;
        next_wrAddr        = addrPhase ? haddr[7:0] : wrAddr;
        next_hrdata        = hrdata;
        next_chargeConfig  = chargeConfig;
        next_statusFunc    = statusFunc;
        next_limitCode     = limitCode;
        next_limitOverride = limitOverride;
        next_dplusSet      = dplusSet;
        next_dminusSet     = dminusSet;
        // a write lands at the end of its data phase, when hwdata stands;
        // a back-to-back read of the same word therefore sees the new value
        // only if its address phase follows the write's data phase
        if (wrPend) begin
            case (wrAddr)
                REG_CTRL: begin
                    next_chargeConfig = hwdata[CTRL_CHGCFG_BIT];
                    next_statusFunc   = hwdata[CTRL_STFUNC_LSB +: 2];
                end
                REG_ILIM: begin
                    next_limitCode     = hwdata[ILIM_CODE_LSB +: 5];
                    next_limitOverride = hwdata[ILIM_VALID_BIT];
                end
                REG_DLINE: begin
                    next_dplusSet  = hwdata[DLINE_DP_LSB +: 2];
                    next_dminusSet = hwdata[DLINE_DM_LSB +: 2];
                end
                default: begin
                    next_chargeConfig = chargeConfig;                         // unmapped: ignored
                end
            endcase
        end
        // read data prepared at address phase, stands in data phase
        if (addrPhase & ~hwrite) begin
            case (haddr[7:0])
                REG_CTRL:   next_hrdata = {29'h0, statusFunc, chargeConfig};
                REG_ILIM:   next_hrdata = {23'h0, limitOverride, 3'h0, limitCode};
                REG_DLINE:  next_hrdata = {28'h0, dminusSet, dplusSet};
                REG_STATUS: next_hrdata = {inputLimitMa, 12'h0, 1'b0, chargeEnable,
                                           power_good_out_n_oe, faultSuspend,
                                           chargeDone, chargeActive, intCount != 13'h0,
                                           sourceSelect};
                default:    next_hrdata = 32'h0000_0000;                      // unmapped reads zero
            endcase
        end
    end

    // register file and bus pipeline flops
    // reset loads the documented defaults: charging allowed, no override,
    // status pin in its normal function and both data lines at code zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPend        <= 1'b0;
            wrAddr        <= 8'h00;
            hrdata        <= 32'h0000_0000;
            chargeConfig  <= CTRL_RST[CTRL_CHGCFG_BIT];
            statusFunc    <= CTRL_RST[CTRL_STFUNC_LSB +: 2];
            limitCode     <= ILIM_RST[ILIM_CODE_LSB +: 5];
            limitOverride <= ILIM_RST[ILIM_VALID_BIT];
            dplusSet      <= DLINE_RST[DLINE_DP_LSB +: 2];
            dminusSet     <= DLINE_RST[DLINE_DM_LSB +: 2];
        end else begin
            wrPend        <= next_wrPend;
            wrAddr        <= next_wrAddr;
            hrdata        <= next_hrdata;
            chargeConfig  <= next_chargeConfig;
            statusFunc    <= next_statusFunc;
            limitCode     <= next_limitCode;
            limitOverride <= next_limitOverride;
            dplusSet      <= next_dplusSet;
            dminusSet     <= next_dminusSet;
        end
    end


    // the limit output is registered so the power-good compare below
    // always sees a settled value; the cost is one cycle of latency
    // after the source pin or the override changes
    //
    // the interrupt counter is reloaded by any event, so a burst of
    // events gives one long pulse rather than several short ones
    //
    // the blink counter is held in reset outside a fault, which makes
    // every fault start with a full low half period
    // pin behaviour: limit select, interrupt timer, status blink
    always_comb begin
        // default from pin, host code overrides
        if (limitOverride) begin
            next_inputLimitMa = LIM_BASE_MA + 12'(limitCode) * LIM_STEP_MA;
        end else if (sourceSelect) begin
            next_inputLimitMa = LIM_USB_MA;
        end else begin
            next_inputLimitMa = LIM_ADAPTER_MA;
        end
        // rising fault or status event reloads the full width, no host action needed
        next_faultPrev = faultSuspend;
        if (statusEvent | (faultSuspend & ~faultPrev)) begin
            next_intCount = INT_LOAD;
        end else if (intCount != 13'h0) begin
            next_intCount = intCount - 13'h1;
        end else begin
            next_intCount = intCount;
        end
        // blink counter only runs while suspended, so blink starts in low phase
        if (!faultSuspend) begin
            next_blinkCount = 24'h0;
            next_blinkPhase = 1'b1;
        end else if (blinkCount == BLINK_LAST) begin
            next_blinkCount = 24'h0;
            next_blinkPhase = ~blinkPhase;
        end else begin
            next_blinkCount = blinkCount + 24'h1;
            next_blinkPhase = blinkPhase;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            inputLimitMa <= LIM_ADAPTER_MA;
            intCount     <= 13'h0;
            blinkCount   <= 24'h0;
            blinkPhase   <= 1'b1;
            faultPrev    <= 1'b0;
        end else begin
            inputLimitMa <= next_inputLimitMa;
            intCount     <= next_intCount;
            blinkCount   <= next_blinkCount;
            blinkPhase   <= next_blinkPhase;
            faultPrev    <= next_faultPrev;
        end
    end


    // open-drain pins: the block only ever pulls low, the pull-up outside
    // gives the high level; drives are registered so no combinational
    // glitch from the flag inputs can reach a pin
    //
    // fault wins over charging on the status pin, and the disable code
    // wins over both
    // registered pin drives; pin level is always 0 when enabled
    logic next_pgLow;
    logic next_statLow;
    logic pgLow;
    logic statLow;

    always_comb begin
        next_pgLow = aboveUvlo & belowOvp & aboveSleep & (inputLimitMa > LIM_PG_MIN_MA);
        if (statusFunc == STFUNC_OFF) begin
            next_statLow = 1'b0;
        end else if (faultSuspend) begin
            next_statLow = blinkPhase;
        end else if (chargeActive & ~chargeDone) begin
            next_statLow = 1'b1;
        end else begin
            next_statLow = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pgLow   <= 1'b0;
            statLow <= 1'b0;
        end else begin
            pgLow   <= next_pgLow;
            statLow <= next_statLow;
        end
    end


    // pin and field outputs
    // the interrupt enable comes straight from the counter flops, so it
    // rises in the cycle after the event and never glitches
    // charge enable is combinational: the enable pin acts without delay
    assign power_good_out_n_oe      = pgLow;
    assign power_good_out_n_o       = 1'b0;
    assign statusPin_oe             = statLow;
    assign statusPin_o              = 1'b0;
    assign interrupt_pulse_out_n_oe = intCount != 13'h0;
    assign interrupt_pulse_out_n_o  = 1'b0;
    assign dplusVoltageSet          = dplusSet;
    assign dminusVoltageSet         = dminusSet;
    assign chargeEnable             = chargeConfig & ~charge_enable_pin_n;

endmodule

// *** common/cscp_pkg.sv ***
// cscp_pkg: constants, register map and encodings of the charger status/control pin block
// assumes a 25 MHz system clock and an AHB-Lite register bus with 32-bit data
//
// Function
// - Source pin high 500mA, low 2.4A default
// - Host-written 5-bit limit overrides pin default
// - Two 2-bit fields set D+ and D- voltages
// - Power-good low only when all input conditions good
// - Status pin low while charging
// - Status pin released when done or sleeping; the status pin logic does not use aboveSleep
// - Status pin blinks 1Hz 50% on fault suspend
// - 2-bit field disables status pin function
// - Interrupt low pulse 256us per status/fault event; an event during a pulse restarts the 256us, giving one longer pulse
// - Charge enabled when config bit 1 and pin low
// - Fault interrupt issued at once, no host action
package cscp_pkg;

    // timing
    localparam int CLK_HZ          = 25000000;           // system clock rate
    localparam int INT_PULSE_NS    = 256000;             // interrupt pulse width, 256 us
    localparam int INT_PULSE_CYC   = (INT_PULSE_NS * 25) / 1000; // 6400 cycles at 25 MHz (exact, no rounding)
    localparam int BLINK_HZ        = 1;                  // status blink rate
    localparam int BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ); // half period, 50% duty

    // current limit codes, in mA
    localparam logic [11:0] LIM_USB_MA     = 12'h1F4;    // 500 mA
    localparam logic [11:0] LIM_ADAPTER_MA = 12'h960;    // 2400 mA
    localparam logic [11:0] LIM_PG_MIN_MA  = 12'h01E;    // 30 mA power-good floor
    localparam logic [11:0] LIM_STEP_MA    = 12'h064;    // 100 mA per code step
    localparam logic [11:0] LIM_BASE_MA    = 12'h064;    // code 0 equals 100 mA

    // register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;          // control
    localparam logic [7:0] REG_ILIM    = 8'h04;          // input current limit
    localparam logic [7:0] REG_DLINE   = 8'h08;          // data line voltages
    localparam logic [7:0] REG_STATUS  = 8'h0C;          // status, read only

    // control register fields
    localparam int CTRL_CHGCFG_BIT = 0;                  // charge_config_bit
    localparam int CTRL_STFUNC_LSB = 1;                  // status_pin_function_select [2:1]
    // limit register fields
    localparam int ILIM_CODE_LSB   = 0;                  // input_current_limit_field [4:0]
    localparam int ILIM_VALID_BIT  = 8;                  // host override active
    // data line register fields
    localparam int DLINE_DP_LSB    = 0;                  // dplus_voltage_set [1:0]
    localparam int DLINE_DM_LSB    = 2;                  // dminus_voltage_set [3:2]

    // reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0001;  // charging allowed, status pin on
    localparam logic [31:0] ILIM_RST   = 32'h0000_0000;  // no override
    localparam logic [31:0] DLINE_RST  = 32'h0000_0000;  // both lines hi-z code

    // status pin function select codes
    localparam logic [1:0] STFUNC_ON   = 2'h0;           // normal status indication
    localparam logic [1:0] STFUNC_OFF  = 2'h3;           // status pin released

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// *** testbench/cscp_charger_pins_monitor.sv ***
// cscp_charger_pins_monitor: port-level checks of the charger pin block
// assumes a bind to cscp_charger_pins and word-wide bus writes only
`timescale 1ns/10ps
module cscp_charger_pins_monitor
    import cscp_pkg::*;
(
    input wire logic        clock,                   // system clock
    input wire logic        rst_b,                   // async reset
    input wire logic        hsel,                    // bus select
    input wire logic [31:0] haddr,                   // bus address
    input wire logic [1:0]  htrans,                  // transfer type
    input wire logic        hwrite,                  // write flag
    input wire logic [31:0] hwdata,                  // write data
    input wire logic        sourceSelect,            // source pin
    input wire logic        charge_enable_pin_n,     // enable pin
    input wire logic        aboveUvlo,               // above lockout
    input wire logic        belowOvp,                // below overvoltage
    input wire logic        aboveSleep,              // above sleep level
    input wire logic        chargeActive,            // charging
    input wire logic        faultSuspend,            // fault suspend
    input wire logic        statusEvent,             // status event
    input wire logic [11:0] inputLimitMa,            // limit out
    input wire logic        chargeEnable,            // enable out
    input wire logic        power_good_out_n_oe,     // power-good pull
    input wire logic        statusPin_oe,            // status pull
    input wire logic        interrupt_pulse_out_n_oe // interrupt pull
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic        wrPend; // write data phase due
    logic [7:0]  wrAddr; // captured offset
    logic [2:0]  ctrl;   // shadow function and config
    logic [5:0]  ilim;   // shadow override and code
    logic [12:0] intCnt; // pulse cycles left
    logic [1:0]  live;   // edges since reset
    logic [11:0] expLim; // expected limit
    // shadow registers and pulse timer, one flop group to save space
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            {wrPend, wrAddr, ilim, live, intCnt} <= '0;
            ctrl <= CTRL_RST[2:0];
        end else begin
            wrPend <= hsel & htrans[1] & hwrite;
            wrAddr <= haddr[7:0];
            live   <= {live[0], 1'b1};
            if (wrPend && wrAddr == REG_CTRL) ctrl <= hwdata[2:0];
            if (wrPend && wrAddr == REG_ILIM) ilim <= {hwdata[8], hwdata[4:0]};
            // a new event reloads the full width
            if (statusEvent || $rose(faultSuspend)) intCnt <= 13'(INT_PULSE_CYC);
            else if (intCnt != 13'h0) intCnt <= intCnt - 13'h1;
        end
    end
    assign expLim = ilim[5] ? 12'(LIM_BASE_MA + LIM_STEP_MA * ilim[4:0]) : (sourceSelect ? LIM_USB_MA : LIM_ADAPTER_MA);
    a_int_pulse_width: assert property (interrupt_pulse_out_n_oe == (intCnt != 13'h0))
        else $error("interrupt pulse width wrong");
    a_fault_int_now: assert property ($rose(faultSuspend) |=> interrupt_pulse_out_n_oe)
        else $error("fault gave no interrupt");
    a_limit_select: assert property (live[1] && $stable(expLim) && expLim == $past(expLim, 2) |-> inputLimitMa == expLim)
        else $error("input limit wrong");
    a_charge_gate: assert property (chargeEnable == (ctrl[0] && !charge_enable_pin_n))
        else $error("charge enable wrong");
    a_power_good: assert property (live[1] |-> power_good_out_n_oe == $past(aboveUvlo && belowOvp && aboveSleep && inputLimitMa > LIM_PG_MIN_MA))
        else $error("power good wrong");
    a_stat_charging: assert property (chargeActive && !faultSuspend && ctrl[2:1] != STFUNC_OFF |=> statusPin_oe)
        else $error("status not low while charging");
    a_stat_release: assert property (ctrl[2:1] == STFUNC_OFF || !(chargeActive || faultSuspend) |=> !statusPin_oe)
        else $error("status not released");
    a_blink_low_first: assert property ($rose(faultSuspend) && ctrl[2:1] != STFUNC_OFF |=> statusPin_oe)
        else $error("blink did not start low");
    c_int_restart: cover property (statusEvent && intCnt != 13'h0);
    c_fault_blink: cover property ($rose(faultSuspend));
    c_override: cover property (ilim[5] && inputLimitMa == expLim);
endmodule

// *** testbench/cscp_host_pins.sv ***
// cscp_host_pins: host side of the open-drain pins, pull-ups and a pulse timer
// assumes each pin has a pull-up and only the block pulls it low
`timescale 1ns/10ps
module cscp_host_pins (
    input wire logic clock,     // system clock
    input wire logic pgOe,      // power-good pull
    input wire logic statOe,    // status pull
    input wire logic intOe,     // interrupt pull
    output logic     pgPin,     // power-good level
    output logic     statPin,   // status level
    output logic     intPin,    // interrupt level
    output int       lowCycles  // last interrupt low run
);
    int run; // current low run
    // released pins float to the pull-up level
    assign pgPin   = !pgOe;
    assign statPin = !statOe;
    assign intPin  = !intOe;
    // host timer measures each low run of the interrupt pin
    always_ff @(posedge clock) begin
        run <= intPin ? 0 : run + 1;
        if (intPin && run != 0) lowCycles <= run;
    end
endmodule

// *** testbench/tb.sv ***
// tb: random and corner stimulus for the charger pin block with a host pin model
// assumes a zero-wait bus slave; expectations come from package constants
`timescale 1ns/10ps
module tb;
    import cscp_pkg::*;
    logic        clock = 0, rst_b = 0, hsel = 0, hwrite = 0;           // clock, reset, bus control
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, code, seed = 32'h5319; // bus data, random state
    logic [1:0]  htrans = 0, dpV, dmV;                                 // transfer type, line codes
    logic        srcSel = 1, cePin = 0, undervoltage_lockout = 1, ovp = 1, slp = 1;   // pins and flags
    logic        act = 0, done = 0, flt = 0, evt = 0;                 // charger state
    logic        hreadyout, chgEn, pgOe, stOe, intOe, pgPin, statPin, intPin; // outputs
    logic [11:0] lim;                                                 // effective limit
    int          n_fail = 0, checks_done = 0, lowCycles, i;           // counters
    localparam logic [4:0] stTab [5] = '{5'b00100, 5'b10010, 5'b10000, 5'b11100, 5'b00001}; // exp,off,act,done,flt
    cscp_charger_pins dut (
        .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .sourceSelect(srcSel), .charge_enable_pin_n(cePin), .aboveUvlo(undervoltage_lockout), .belowOvp(ovp),
        .aboveSleep(slp), .chargeActive(act), .chargeDone(done), .faultSuspend(flt), .statusEvent(evt),
        .inputLimitMa(lim), .dplusVoltageSet(dpV), .dminusVoltageSet(dmV), .chargeEnable(chgEn),
        .power_good_out_n_oe(pgOe), .power_good_out_n_o(), .statusPin_oe(stOe), .statusPin_o(),
        .interrupt_pulse_out_n_oe(intOe), .interrupt_pulse_out_n_o());
    cscp_host_pins host (.clock(clock), .pgOe(pgOe), .statOe(stOe), .intOe(intOe), .pgPin(pgPin),
        .statPin(statPin), .intPin(intPin), .lowCycles(lowCycles));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait: bus ready, or interrupt pin back high
    task automatic waitOn(input bit onInt);
        for (int k = 0; k < 9000; k++) begin
            @(posedge clock);
            if (onInt ? (k > 1 && intPin === 1'b1) : (hreadyout === 1'b1)) return;
        end
        n_fail++;
        stop_test();
    endtask
    // one single-word transfer; rd holds read data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        waitOn(0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitOn(0);
        rd = hrdata;
    endtask
    initial begin
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 4; i++) begin
            bus(0, i == 3 ? 8'h10 : 8'(4 * i), 0);
            check(rd, i == 0 ? CTRL_RST : 32'h0);
        end
        for (i = 0; i < 2; i++) begin
            srcSel <= i[0];
            repeat (3) @(posedge clock);
            check(32'(lim), 32'(i[0] ? LIM_USB_MA : LIM_ADAPTER_MA));
        end
        // override wins whatever the source pin does, codes at both ends
        for (i = 0; i < 6; i++) begin
            code = (i == 0) ? 32'h0 : (i == 1) ? 32'h1F : rnd() & 32'h1F;
            srcSel <= ~srcSel;
            bus(1, REG_ILIM, 32'h100 | code);
            repeat (2) @(posedge clock);
            check(32'(lim), 32'(LIM_BASE_MA + LIM_STEP_MA * code[4:0]));
        end
        bus(1, REG_ILIM, 0);
        for (i = 0; i < 16; i++) begin
            bus(1, REG_DLINE, 32'(i));
            @(posedge clock);
            check(32'({dmV, dpV}), 32'(i));
        end
        for (i = 0; i < 4; i++) begin
            bus(1, REG_CTRL, 32'(i[0]));
            cePin <= i[1];
            @(posedge clock);
            check(32'(chgEn), 32'(i[0] & ~i[1]));
        end
        cePin <= 1'b0;
        for (i = 0; i < 8; i++) begin
            {undervoltage_lockout, ovp, slp} <= 3'(i);
            repeat (2) @(posedge clock);
            check(32'(pgPin), 32'(i != 7));
        end
        // status word: limit on top, then enable, power good, idle flags, source pin
        bus(0, REG_STATUS, 0);
        check(rd, {srcSel ? LIM_USB_MA : LIM_ADAPTER_MA, 13'h0, 2'b11, 3'h0, 1'b0, srcSel});
        foreach (stTab[k]) begin
            bus(1, REG_CTRL, stTab[k][3] ? 32'h7 : 32'h1);
            {act, done, flt} <= stTab[k][2:0];
            repeat (3) @(posedge clock);
            check(32'(statPin), 32'(stTab[k][4]));
        end
        flt <= 1'b0;
        waitOn(1);
        repeat (2) @(posedge clock);
        check(lowCycles, INT_PULSE_CYC);
        evt <= 1'b1;
        @(posedge clock);
        evt <= 1'b0;
        repeat (999) @(posedge clock);
        evt <= 1'b1;
        @(posedge clock);
        evt <= 1'b0;
        waitOn(1);
        repeat (2) @(posedge clock);
        check(lowCycles, INT_PULSE_CYC + 1000);
        stop_test();
    end
endmodule
bind cscp_charger_pins cscp_charger_pins_monitor mon (.*);
